// ---- src/digital_output_cfg_watchdog_fuse.sv ----
// Configuration, watchdog and blown-fuse control of a 16-channel output module
// Assumes an APB master on ref_clk and an unsynchronised fuse-blown sense line
// Assumes the output data word sits at word 0 beside the configuration word
// clkEn low freezes every register and holds the bus master off
//
// What this block does
// RL1 - Word 13 writes configuration, reads status.
// RL2 - Writing one to bit 0 sets configured until reset.
// RL3 - Power-up clears the whole configuration register.
// RL4 - Forced error lights internal fault, data writable but reads zero.
// RL5 - Bits 2 to 4 select the watchdog timeout.
// RL6 - Codes 0..7 map to 16s,4s,2s,1s,500,250,125,62 ms.
// RL7 - Each timeout within 35 percent of nominal.
// RL8 - After power-up the 16 second timeout applies.
// RL9 - Any read or write restarts the watchdog.
// RL10 - On expiry outputs hold if bit 5, else go off.
// RL11 - Status returns bits 0 to 5 and 7 in place.
// RL12 - Bit 7 enables fuse detection; bit 6 ignored on writes.
// RL13 - Enabled: blown sense sets status 6 and external fault.
// RL14 - Disabled: status 6 zero and external fault off.
// RL15 - Detection starts disabled after reset.
// RL16 - External fault only when blown and enabled.
// RL17 - Internal fault when forced error or watchdog expired.
// RL18 - Communications lamp lit while watchdog not expired.
// RL19 - Sixteen channel lamps follow the output states.
// RL20 - Fuse sense synchronised before use.
// RL21 - Periods derived from module clock by a prescaler.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "dout_map.svh"

module digital_output_cfg_watchdog_fuse
  import dout_pkg::*;
#(
  parameter int CHANNELS     = 16,
  parameter int TICKS_PER_MS = `TICKS_PER_MS
) (
  // Clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clkEn,
  // APB slave
  input  wire apb_req_t             apbReq,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Field side
  input  wire logic                 fuseBlownRaw,
  output logic [CHANNELS-1:0]       outputDrive,
  // Indicators
  output lamp_t                     lamps,
  output logic [CHANNELS-1:0]       channel_state_lamps
);

  if (CHANNELS < 1 || CHANNELS > 32) begin : gChkCh
    $error("CHANNELS must lie in 1..32");
  end
  if (TICKS_PER_MS < 1) begin : gChkTick
    $error("TICKS_PER_MS must be at least 1");
  end

  localparam int PRE_W = $clog2(TICKS_PER_MS + 1);
  localparam int MS_W  = 15;
  localparam logic [`ADDR_W-1:0] CFG_ADDR = `ADDR_W'(4 * `CFG_STAT_INDEX);
  localparam logic [`ADDR_W-1:0] OUT_ADDR = `ADDR_W'(4 * `OUT_DATA_INDEX);

  localparam int PERIOD_MS [8] = '{`TMO_MS_0, `TMO_MS_1, `TMO_MS_2, `TMO_MS_3,
                                   `TMO_MS_4, `TMO_MS_5, `TMO_MS_6, `TMO_MS_7};

  // RL6 every period must be nonzero and fit the millisecond counter
  for (genvar p = 0; p < 8; p++) begin : gChkPeriod
    if (PERIOD_MS[p] < 1 || PERIOD_MS[p] >= (1 << MS_W)) begin : gBad
      $error("watchdog period out of range");
    end
  end

  // The configuration word must be reachable and distinct from the data word
  if (4 * `CFG_STAT_INDEX >= (1 << `ADDR_W) || `CFG_STAT_INDEX == `OUT_DATA_INDEX) begin : gChkMap
    $error("register map does not fit the address bus");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic setupPh;
  logic accessPh;
  logic hitCfg;
  logic hitOut;
  logic wrCfg;
  logic wrOut;

  assign setupPh  = apbReq.psel && !apbReq.penable;
  assign accessPh = apbReq.psel && apbReq.penable && clkEn;
  // RL1 word decode
  assign hitCfg   = apbReq.paddr == CFG_ADDR;
  assign hitOut   = apbReq.paddr == OUT_ADDR;
  assign wrCfg    = accessPh && apbReq.pwrite && hitCfg;
  assign wrOut    = accessPh && apbReq.pwrite && hitOut;
  logic wdRestart;

  // RL9 any access phase, mapped or not, feeds the watchdog
  assign wdRestart = accessPh;

  //////////////////////////////////////////////////////////////////////////////
  // Bus response

  // Zero wait states; a frozen block holds the master off
  assign pready   = clkEn;
  // Unmapped words answer with an error and still restart the watchdog
  assign pslverr  = apbReq.psel && apbReq.penable && !(hitCfg || hitOut);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register

  cfg_t cfg_q;
  cfg_t cfg_d;

  localparam cfg_t CFG_INIT = cfg_t'(`CFG_RESET);

  // RL2 configured is sticky
  // RL12 bit 7 enables, bit 6 dropped
  always_comb begin
    cfg_d = cfg_q;
    if (wrCfg) begin
      cfg_d.configured = cfg_q.configured | apbReq.pwdata[`BIT_CONFIGURED];
      cfg_d.forcedErr  = apbReq.pwdata[`BIT_FORCED_ERR];
      // RL5 timeout select field
      cfg_d.tmoSel     = apbReq.pwdata[`FLD_TMO_HI:`FLD_TMO_LO];
      cfg_d.holdOnTmo  = apbReq.pwdata[`BIT_HOLD];
      cfg_d.unused     = 1'b0;
      cfg_d.fuseEn     = apbReq.pwdata[`BIT_FUSE_EN];
    end
  end

  // RL3 clear at power-up
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_INIT;
    end else if (clkEn) begin
      cfg_q <= cfg_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output data register

  logic [CHANNELS-1:0] outData_q;
  logic [CHANNELS-1:0] outData_d;

  // RL4 data stays writable even while forced error hides it
  assign outData_d = wrOut ? apbReq.pwdata[CHANNELS-1:0] : outData_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      outData_q <= CHANNELS'(`OUT_RESET);
    end else if (clkEn) begin
      outData_q <= outData_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fuse sense synchroniser

  logic fuseMeta_q;
  logic fuseSync_q;

  // Raw sense may change at any time; only the second stage is read
  // RL20 two-stage sync
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fuseMeta_q <= 1'b0;
      fuseSync_q <= 1'b0;
    end else if (clkEn) begin
      fuseMeta_q <= fuseBlownRaw;
      fuseSync_q <= fuseMeta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fuse status

  logic fuseBlown;

  // RL13 RL14 RL15 gated by enable
  always_comb begin
    fuseBlown = 1'b0;
    if (cfg_q.fuseEn) begin
      fuseBlown = fuseSync_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Communications watchdog

  logic [PRE_W-1:0] pre_q;
  logic [MS_W-1:0]  ms_q;
  logic [MS_W-1:0]  limitMs;
  logic             msTick;
  wd_state_t        wd_q;

  //////////////////////////////////////////////////////////////////////////////
  // Period table

  // RL6 RL8 period table, code 0 is reset default
  always_comb begin
    case (cfg_q.tmoSel)
      3'h0:    limitMs = MS_W'(`TMO_MS_0);
      3'h1:    limitMs = MS_W'(`TMO_MS_1);
      3'h2:    limitMs = MS_W'(`TMO_MS_2);
      3'h3:    limitMs = MS_W'(`TMO_MS_3);
      3'h4:    limitMs = MS_W'(`TMO_MS_4);
      3'h5:    limitMs = MS_W'(`TMO_MS_5);
      3'h6:    limitMs = MS_W'(`TMO_MS_6);
      3'h7:    limitMs = MS_W'(`TMO_MS_7);
      default: limitMs = MS_W'(`TMO_MS_0);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond prescaler

  logic [PRE_W-1:0] pre_d;

  // RL21 millisecond prescaler
  assign msTick = pre_q == PRE_W'(TICKS_PER_MS - 1);

  // RL9 restart on access so a fresh period starts cleanly
  always_comb begin
    pre_d = pre_q + PRE_W'(1);
    if (wdRestart || msTick) begin
      pre_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_q <= '0;
    end else if (clkEn) begin
      pre_q <= pre_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog state

  logic [MS_W-1:0] ms_d;
  logic            limitHit;

  // RL9 any read or write clears the elapsed count
  always_comb begin
    ms_d = ms_q;
    if (wdRestart || wd_q == WdExpired) begin
      ms_d = '0;
    end else if (msTick) begin
      ms_d = ms_q + MS_W'(1);
    end
  end

  // RL7 exact period, well within tolerance
  assign limitHit = msTick && (ms_q + MS_W'(1) >= limitMs);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ms_q <= '0;
    end else if (clkEn) begin
      ms_q <= ms_d;
    end
  end

  // Run until the selected count is reached, then wait for an access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wd_q <= WdRun;
    end else if (clkEn) begin
      if (wdRestart) begin
        wd_q <= WdRun;
      end else begin
        case (wd_q)
          WdRun:     wd_q <= limitHit ? WdExpired : WdRun;
          WdExpired: wd_q <= WdExpired;
          default:   wd_q <= WdRun;
        endcase
      end
    end
  end

  logic expired;
  assign expired = wd_q == WdExpired;

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rdWord_d;

  // RL11 status mirrors configuration, bit 6 from the fuse sense
  // RL4 data hidden while forced error
  always_comb begin
    rdWord_d = '0;
    if (hitCfg) begin
      rdWord_d[7:0] = {cfg_q.fuseEn, fuseBlown, cfg_q.holdOnTmo, cfg_q.tmoSel,
                       cfg_q.forcedErr, cfg_q.configured};
    end else if (hitOut && !cfg_q.forcedErr) begin
      rdWord_d[CHANNELS-1:0] = outData_q;
    end
  end

  // Loaded in the setup cycle so it stands through the access phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (clkEn && setupPh) begin
      prdata <= rdWord_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs and indicators

  logic [CHANNELS-1:0] chanOn_d;
  logic                dropOutputs;

  // RL10 outputs go off on expiry unless hold is selected
  assign dropOutputs = expired && !cfg_q.holdOnTmo;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChan
    assign chanOn_d[ch] = outData_q[ch] && !dropOutputs;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      outputDrive <= '0;
    end else if (clkEn) begin
      outputDrive <= chanOn_d;
    end
  end

  // RL19 lamp per channel
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      channel_state_lamps <= '0;
    end else if (clkEn) begin
      channel_state_lamps <= chanOn_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Indicator lamps

  logic extFault_q;
  logic intFault_q;
  logic commOk_q;

  // RL16 external fault lamp
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      extFault_q <= 1'b0;
    end else if (clkEn) begin
      extFault_q <= fuseBlown;
    end
  end

  // RL17 RL4 internal fault lamp
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      intFault_q <= 1'b0;
    end else if (clkEn) begin
      intFault_q <= cfg_q.forcedErr || expired;
    end
  end

  // RL18 communications lamp, dark during reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      commOk_q <= 1'b0;
    end else if (clkEn) begin
      commOk_q <= !expired;
    end
  end

  assign lamps = {commOk_q, intFault_q, extFault_q};

endmodule

// ---- common/dout_map.svh ----
// Register map, field positions, reset values and timing counts
// Assumes a 200 MHz module clock and a 32-bit APB register bus
`ifndef DOUT_MAP_SVH
`define DOUT_MAP_SVH

// Register indices; byte address is four times the index
`define CFG_STAT_INDEX    13
`define OUT_DATA_INDEX    0
`define ADDR_W            8

// Configuration / status fields
`define BIT_CONFIGURED    0
`define BIT_FORCED_ERR    1
`define FLD_TMO_LO        2
`define FLD_TMO_HI        4
`define BIT_HOLD          5
`define BIT_FUSE_BLOWN    6
`define BIT_FUSE_EN       7
`define CFG_RESET         8'h00
`define OUT_RESET         16'h0000

// Timing
`define CLK_PERIOD_NS     5
`define MS_NS             1000000
`define TICKS_PER_MS      (`MS_NS / `CLK_PERIOD_NS)
`define TMO_MS_0          16000
`define TMO_MS_1          4000
`define TMO_MS_2          2000
`define TMO_MS_3          1000
`define TMO_MS_4          500
`define TMO_MS_5          250
`define TMO_MS_6          125
`define TMO_MS_7          62

`endif

// ---- common/dout_pkg.sv ----
// Types shared by the digital output control block
// Assumes dout_map.svh sits on the include path
`include "dout_map.svh"
package dout_pkg;
  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [`ADDR_W-1:0]  paddr;
    logic [31:0]         pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        fuseEn;
    logic [6:6]  unused;
    logic        holdOnTmo;
    logic [2:0]  tmoSel;
    logic        forcedErr;
    logic        configured;
  } cfg_t;

  typedef struct packed {
    logic commOk;
    logic intFault;
    logic extFault;
  } lamp_t;

  typedef enum logic [1:0] {
    WdRun,
    WdExpired
  } wd_state_t;
endpackage

// ---- verif/dout_chk.sv ----
// Port checks for the output control block
// Bound to its top; one clock domain, sync reset
`timescale 1ns/10ps
module dout_chk
  import dout_pkg::*;
#(
  parameter int CHANNELS     = 16,
  parameter int TICKS_PER_MS = 200000
) (
  // Clock
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic                clkEn,
  // Bus
  input wire apb_req_t            apbReq,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Field
  input wire logic                fuseBlownRaw,
  input wire logic [CHANNELS-1:0] outputDrive,
  input wire lamp_t               lamps,
  input wire logic [CHANNELS-1:0] channel_state_lamps
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence acc;
    apbReq.psel && apbReq.penable && clkEn;
  endsequence
  sequence idleExp;
    (!lamps.commOk && !apbReq.psel)[*3];
  endsequence
  chk_lamp_follow: assert property (channel_state_lamps == outputDrive)
    else $error("lamp mismatch");
  chk_addr_decode: assert property (acc |-> pslverr == !(apbReq.paddr inside {8'h00, 8'h34}))
    else $error("bad slverr");
  chk_forced_read: assert property (
    acc ##0 (!apbReq.pwrite && apbReq.paddr == 8'h00 && lamps.intFault && lamps.commOk) |-> prdata == 32'h0)
    else $error("data readable");
  chk_comm_restart: assert property (acc |-> ##[1:3] lamps.commOk)
    else $error("no restart");
  chk_int_expiry: assert property ($fell(lamps.commOk) |-> ##[0:1] lamps.intFault)
    else $error("no int fault");
  chk_hold_state: assert property (idleExp |=> $stable(outputDrive))
    else $error("outputs moved");
  chk_fuse_sync: assert property ($rose(fuseBlownRaw) && !lamps.extFault |=> !lamps.extFault)
    else $error("fuse unsynced");
  chk_fuse_quiet: assert property (!fuseBlownRaw [*5] |-> !lamps.extFault)
    else $error("false ext fault");
endmodule
bind digital_output_cfg_watchdog_fuse dout_chk #(.CHANNELS(CHANNELS), .TICKS_PER_MS(TICKS_PER_MS)) i_dout_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fuseBlownRaw(fuseBlownRaw), .outputDrive(outputDrive), .lamps(lamps),
  .channel_state_lamps(channel_state_lamps));

// ---- verif/apb_ctl.sv ----
// Bus controller model issuing APB transfers
// Assumes the slave answers through pready
`timescale 1ns/10ps
module apb_ctl
  import dout_pkg::*;
(
  // Clock
  input wire logic        ref_clk,
  // Bus
  output apb_req_t        req,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    req <= {2'b10, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= {2'b00, ~req[40:0]};
    @(posedge ref_clk);
  endtask
endmodule

// ---- verif/digital_output_cfg_watchdog_fuse_tb.sv ----
// Self-checking bench for the output control block
// Millisecond tick shortened to one clock
`timescale 1ns/10ps
module digital_output_cfg_watchdog_fuse_tb
  import dout_pkg::*;
;
  localparam int TPM = 1;
  logic        ref_clk;
  logic        sys_rst;
  logic        clkEn;
  logic        fuseRaw;
  apb_req_t    apbReq;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] outDrv;
  lamp_t       lamps;
  logic [15:0] chLamps;
  logic [31:0] rd;
  logic        er;
  int          errCount;
  int          totalChecks;
  int          ms[8] = '{16000, 4000, 2000, 1000, 500, 250, 125, 62};

  digital_output_cfg_watchdog_fuse #(.TICKS_PER_MS(TPM)) i_digital_output_cfg_watchdog_fuse (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuseBlownRaw(fuseRaw), .outputDrive(outDrv), .lamps(lamps), .channel_state_lamps(chLamps));
  apb_ctl i_apb_ctl (.ref_clk(ref_clk), .req(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_apb_ctl.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    i_apb_ctl.xfer(1'b0, a, 32'h0, rd, er);
    chk(nm, rd, exp);
  endtask
  task automatic lmp(input lamp_t exp);
    @(negedge ref_clk);
    chk("lamps", {29'h0, lamps}, {29'h0, exp});
    @(posedge ref_clk);
  endtask
  task automatic wdog(input int t, input logic [15:0] o);
    repeat (t * TPM * 9 / 10) @(posedge ref_clk);
    lmp(3'b100);
    repeat (t * TPM / 5) @(posedge ref_clk);
    lmp(3'b010);
    chk("outputs", {16'h0, outDrv}, {16'h0, o});
  endtask
  task automatic conclude();
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    errCount++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    clkEn   = 1'b1;
    fuseRaw = 1'b0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdc(8'h34, 32'h0, "cfg reset");
    wdog(16000, 16'h0);
    wr(8'h00, 32'hA5C3);
    rdc(8'h00, 32'hA5C3, "data");
    chk("chan lamps", {16'h0, chLamps}, 32'hA5C3);
    wr(8'h34, 32'h3);
    rdc(8'h00, 32'h0, "forced read");
    lmp(3'b110);
    wr(8'h34, 32'h40);
    rdc(8'h34, 32'h1, "cfg sticky");
    rdc(8'h08, 32'h0, "unmapped");
    chk("slverr", {31'h0, er}, 32'h1);
    wr(8'h34, 32'h81);
    fuseRaw <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc(8'h34, 32'hC1, "fuse status");
    lmp(3'b101);
    wr(8'h34, 32'h41);
    rdc(8'h34, 32'h01, "fuse off");
    lmp(3'b100);
    fuseRaw <= 1'b0;
    foreach (ms[c]) begin
      wr(8'h34, 32'h21 | (c << 2));
      rdc(8'h34, 32'h21 | (c << 2), "cfg echo");
      wdog(ms[c], 16'hA5C3);
    end
    wr(8'h34, 32'h1D);
    wdog(62, 16'h0);
    rdc(8'h00, 32'hA5C3, "data kept");
    lmp(3'b100);
    clkEn <= 1'b0;
    @(posedge ref_clk);
    chk("pready frozen", {31'h0, pready}, 32'h0);
    repeat (100) @(posedge ref_clk);
    lmp(3'b100);
    clkEn <= 1'b1;
    repeat (40) @(posedge ref_clk);
    lmp(3'b100);
    conclude();
  end
endmodule
